/* File: hw/wdt_cfg.svh */
// Constants for the watchdog timer: register indices, fields, reset values and counts
// Notes on behaviour
// R1 - Fifteen-bit counter decrements once per count tick
// R2 - Protection off: ticks come from CPU clock
// R3 - Protection on: ticks come from 125 kHz oscillator
// R4 - Write 00h then FFh reloads; reset, underflow too
// R5 - Protection off: period is ratio times 32768 clocks
// R6 - Protection on: period is 4096 oscillator cycles
// R7 - Autostart disabled: stopped until start register written
// R8 - Autostart enabled: counts right after reset
// R9 - Protection off: freeze in stop, wait, hold
// R10 - Protection on: keep counting, refuse stop mode; code blocks stop entry only once the watchdog has started
// R11 - Protection off: underflow gives interrupt or reset
// R12 - Protection on: underflow always gives reset
// R13 - Protection set by writing 0 then 1; never cleared
// R14 - Protection-at-reset option loads protect register 80h
// R15 - Option byte from flash, erased value FFh
// R16 - Protection-at-reset also needs autostart enabled; code sets protection from the option bit 7 alone, whatever the autostart bit
// R17 - Program cannot change the autostart option bit
// R18 - Prescaler cleared only by reset, not refresh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// Register word indices, byte address is four times the index
`define WDT_IDX_REFRESH 30'h00000000
`define WDT_IDX_START 30'h00000001
`define WDT_IDX_CONTROL 30'h00000002
`define WDT_IDX_PROTECT 30'h00000003
`define WDT_IDX_STATUS 30'h00000004
`define WDT_IDX_MASK 30'h00000005
`define WDT_IDX_COUNT 30'h00000006
`define WDT_IDX_OPTION 30'h000fffff

// Refresh sequence bytes
`define WDT_REFRESH_FIRST 8'h00
`define WDT_REFRESH_SECOND 8'hff

// Field positions
`define WDT_CTL_PSEL_BIT 7
`define WDT_CTL_URS_BIT 1
`define WDT_CSP_EN_BIT 7
`define WDT_OPT_WDTOFF_BIT 0
`define WDT_OPT_CSPINI_BIT 7
`define WDT_ST_UFL_INT_BIT 0
`define WDT_ST_UFL_RST_BIT 1

// Reset and erased values
`define WDT_CSP_AT_RESET 8'h80
`define WDT_OPT_ERASED 8'hff
`define WDT_CTL_RESET 8'h00

// Counts
`define WDT_CPU_COUNT 32768
`define WDT_CSP_COUNT 4096
`define WDT_PRE_LO 16
`define WDT_PRE_HI 128

// AXI responses
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

/* File: hw/wdt_pkg.sv */
// Types shared by the watchdog timer modules
package wdt_pkg;
	typedef logic [29:0] wdt_idx_t;
	typedef logic [7:0] wdt_byte_t;
	typedef logic [14:0] wdt_count_t;
	typedef enum logic [0:0]
	{
		WDT_SEQ_IDLE = 1'b0,
		WDT_SEQ_ARMED = 1'b1
	} wdt_seq_t;
endpackage : wdt_pkg

/* File: hw/wdt_regbus_if.sv */
// Internal register access path between the bus slave and the watchdog core
`timescale 1ns/1ns
interface wdt_regbus_if;
	import wdt_pkg::*;
	logic wr_en;
	wdt_idx_t wr_idx;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	wdt_idx_t rd_idx;
	logic [31:0] rd_data;
	logic rd_hit;
	modport bus (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input wr_hit, rd_data, rd_hit);
	modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface : wdt_regbus_if

/* File: hw/wdt_sync.sv */
// Two-stage synchroniser for signals from another clock
`timescale 1ns/1ns
module wdt_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule : wdt_sync

/* File: hw/wdt_axil_slave.sv */
// AXI4-Lite slave front end for the watchdog registers
`timescale 1ns/1ns
`include "wdt_cfg.svh"
module wdt_axil_slave (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write address and data
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	// Write response
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// Read address and data
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Register side
	wdt_regbus_if.bus rb
);
	import wdt_pkg::*;

	logic aw_held_r;
	logic w_held_r;
	logic [31:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic do_write;

	assign s_awready = !aw_held_r && !s_bvalid;
	assign s_wready = !w_held_r && !s_bvalid;
	assign s_arready = !s_rvalid;
	// Write fires once both halves are in, whatever order they came in
	assign do_write = aw_held_r && w_held_r && !s_bvalid;
	assign rb.wr_en = do_write;
	assign rb.wr_idx = awaddr_r[31:2];
	assign rb.wr_data = wdata_r;
	assign rb.wr_strb = wstrb_r;
	assign rb.rd_idx = s_araddr[31:2];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_bvalid <= 1'b0;
			s_bresp <= `WDT_RESP_OKAY;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready)
			begin
				w_held_r <= 1'b1;
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (do_write)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= rb.wr_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
			end
			else if (s_bvalid && s_bready)
				s_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= `WDT_RESP_OKAY;
		end
		else if (s_arvalid && s_arready)
		begin
			s_rvalid <= 1'b1;
			s_rdata <= rb.rd_data;
			s_rresp <= rb.rd_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
		end
		else if (s_rvalid && s_rready)
			s_rvalid <= 1'b0;
	end
endmodule : wdt_axil_slave

/* File: hw/wdt_top.sv */
// Watchdog timer core with count source protection and AXI4-Lite registers
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
`include "wdt_cfg.svh"
module wdt_top #(
	parameter int unsigned CPU_COUNT = `WDT_CPU_COUNT,
	parameter int unsigned CSP_COUNT = `WDT_CSP_COUNT,
	parameter int unsigned PRE_LO = `WDT_PRE_LO,
	parameter int unsigned PRE_HI = `WDT_PRE_HI
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [31:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Low-speed oscillator and option byte
	input wire logic loco_clk_in,
	input wire wdt_pkg::wdt_byte_t option_select_byte,
	// Power mode status
	input wire logic stop_mode,
	input wire logic wait_mode,
	input wire logic hold_state,
	// Outputs
	output logic wdt_irq,
	output logic wdt_reset_req,
	output logic stop_entry_block
);
	import wdt_pkg::*;

	wdt_regbus_if rb ();

	wdt_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.rb(rb.bus)
	);

	logic loco_s;
	logic loco_d_r;
	logic loco_tick;
	logic [2:0] loco_warm_r;

	wdt_sync #(.W(1)) u_loco_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(loco_clk_in),
		.sync_out(loco_s)
	);

	logic init_done_r;
	wdt_byte_t option_r;
	logic started_r;
	logic csp_en_r;
	wdt_seq_t csp_seq_r;
	wdt_seq_t refresh_seq_r;
	wdt_byte_t control_r;
	logic [1:0] status_r;
	logic [1:0] mask_r;
	logic [6:0] pre_r;
	wdt_count_t count_r;

	logic lane0;
	logic wr_refresh;
	logic wr_start;
	logic wr_control;
	logic wr_protect;
	logic wr_status;
	logic wr_mask;
	logic refresh_go;
	logic csp_go;
	logic frozen;
	logic run;
	logic [6:0] pre_max;
	logic cpu_tick;
	logic tick;
	logic underflow;
	logic reset_action;
	wdt_count_t reload;

	assign lane0 = rb.wr_strb[0];
	assign wr_refresh = rb.wr_en && rb.wr_idx == `WDT_IDX_REFRESH && lane0;
	assign wr_start = rb.wr_en && rb.wr_idx == `WDT_IDX_START;
	assign wr_control = rb.wr_en && rb.wr_idx == `WDT_IDX_CONTROL && lane0;
	assign wr_protect = rb.wr_en && rb.wr_idx == `WDT_IDX_PROTECT && lane0;
	assign wr_status = rb.wr_en && rb.wr_idx == `WDT_IDX_STATUS && lane0;
	assign wr_mask = rb.wr_en && rb.wr_idx == `WDT_IDX_MASK && lane0;

	// Option byte index accepts writes but never changes; it lives in flash
	always_comb
	begin
		case (rb.wr_idx)
			`WDT_IDX_REFRESH, `WDT_IDX_START, `WDT_IDX_CONTROL, `WDT_IDX_PROTECT,
			`WDT_IDX_STATUS, `WDT_IDX_MASK, `WDT_IDX_COUNT, `WDT_IDX_OPTION:
				rb.wr_hit = 1'b1;
			default:
				rb.wr_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		rb.rd_hit = 1'b1;
		rb.rd_data = '0;
		case (rb.rd_idx)
			`WDT_IDX_REFRESH: rb.rd_data = '0;
			`WDT_IDX_START: rb.rd_data = '0;
			`WDT_IDX_CONTROL: rb.rd_data = {24'h000000, control_r};
			`WDT_IDX_PROTECT: rb.rd_data = {24'h000000, csp_en_r, 7'h00};
			`WDT_IDX_STATUS: rb.rd_data = {30'h00000000, status_r};
			`WDT_IDX_MASK: rb.rd_data = {30'h00000000, mask_r};
			`WDT_IDX_COUNT: rb.rd_data = {17'h00000, count_r};
			`WDT_IDX_OPTION: rb.rd_data = {24'h000000, option_r};
			default: rb.rd_hit = 1'b0;
		endcase
	end

	// Option byte caught on the first edge after reset release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			init_done_r <= 1'b0;
			option_r <= `WDT_OPT_ERASED; // R15
		end
		else if (!init_done_r)
		begin
			init_done_r <= 1'b1;
			option_r <= option_select_byte; // R15 R17
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			started_r <= 1'b0;
		else if (!init_done_r)
			started_r <= !option_select_byte[`WDT_OPT_WDTOFF_BIT]; // R7 R8
		else if (wr_start)
			started_r <= 1'b1; // R7
	end

	assign csp_go = wr_protect && rb.wr_data[`WDT_CSP_EN_BIT] && csp_seq_r == WDT_SEQ_ARMED;

	// Sticky: only reset clears it, clearing writes are ignored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			csp_en_r <= 1'b0;
			csp_seq_r <= WDT_SEQ_IDLE;
		end
		else if (!init_done_r)
		begin
			csp_en_r <= !option_select_byte[`WDT_OPT_CSPINI_BIT]; // R14
			csp_seq_r <= WDT_SEQ_IDLE;
		end
		else if (wr_protect)
		begin
			if (csp_go)
				csp_en_r <= 1'b1; // R13
			case (csp_seq_r)
				WDT_SEQ_IDLE: csp_seq_r <= rb.wr_data[`WDT_CSP_EN_BIT] ? WDT_SEQ_IDLE : WDT_SEQ_ARMED;
				WDT_SEQ_ARMED: csp_seq_r <= rb.wr_data[`WDT_CSP_EN_BIT] ? WDT_SEQ_IDLE : WDT_SEQ_ARMED;
				default: csp_seq_r <= WDT_SEQ_IDLE;
			endcase
		end
	end

	assign refresh_go = wr_refresh && refresh_seq_r == WDT_SEQ_ARMED &&
		rb.wr_data[7:0] == `WDT_REFRESH_SECOND;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			refresh_seq_r <= WDT_SEQ_IDLE;
		else if (wr_refresh)
		begin
			case (refresh_seq_r)
				WDT_SEQ_IDLE:
					refresh_seq_r <= (rb.wr_data[7:0] == `WDT_REFRESH_FIRST) ? WDT_SEQ_ARMED : WDT_SEQ_IDLE;
				WDT_SEQ_ARMED:
					refresh_seq_r <= (rb.wr_data[7:0] == `WDT_REFRESH_FIRST) ? WDT_SEQ_ARMED : WDT_SEQ_IDLE; // R4
				default:
					refresh_seq_r <= WDT_SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			control_r <= `WDT_CTL_RESET;
		else if (wr_control)
			control_r <= rb.wr_data[7:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			loco_d_r <= 1'b0;
		else
			loco_d_r <= loco_s;
	end

	// Synchroniser restarts from zero; a high pin at release is no edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			loco_warm_r <= 3'h0;
		else
			loco_warm_r <= {loco_warm_r[1:0], 1'b1};
	end

	assign loco_tick = loco_s && !loco_d_r && loco_warm_r[2];
	// Protection keeps counting through low-power states
	assign frozen = !csp_en_r && (stop_mode || wait_mode || hold_state); // R9 R10
	assign run = init_done_r && started_r && !frozen;
	assign pre_max = control_r[`WDT_CTL_PSEL_BIT] ? 7'(PRE_HI - 1) : 7'(PRE_LO - 1); // R5
	assign cpu_tick = run && !csp_en_r && pre_r >= pre_max;
	assign tick = csp_en_r ? (run && loco_tick) : cpu_tick; // R2 R3
	assign reload = csp_en_r ? 15'(CSP_COUNT - 1) : 15'(CPU_COUNT - 1); // R5 R6
	assign underflow = tick && count_r == '0;
	assign reset_action = csp_en_r || control_r[`WDT_CTL_URS_BIT]; // R11 R12

	// Refresh leaves the prescaler alone, so a period may run one step short
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pre_r <= '0; // R18
		else if (run && !csp_en_r)
			pre_r <= cpu_tick ? 7'h00 : pre_r + 7'h01;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_r <= 15'(CPU_COUNT - 1); // R4
		else if (!init_done_r)
			count_r <= option_select_byte[`WDT_OPT_CSPINI_BIT] ? 15'(CPU_COUNT - 1) :
				15'(CSP_COUNT - 1);
		else if (refresh_go || csp_go || underflow)
			count_r <= csp_go ? 15'(CSP_COUNT - 1) : reload; // R4
		else if (tick)
			count_r <= count_r - 15'h0001; // R1
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wdt_reset_req <= 1'b0;
		else
			wdt_reset_req <= underflow && reset_action; // R11 R12
	end

	// Hardware set beats a same-cycle clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status_r <= 2'h0;
		else
		begin
			if (wr_status)
				status_r <= status_r & ~rb.wr_data[1:0];
			if (underflow && !reset_action)
				status_r[`WDT_ST_UFL_INT_BIT] <= 1'b1; // R11
			if (underflow && reset_action)
				status_r[`WDT_ST_UFL_RST_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mask_r <= 2'h0;
		else if (wr_mask)
			mask_r <= rb.wr_data[1:0];
	end

	assign wdt_irq = |(status_r & mask_r);
	assign stop_entry_block = csp_en_r && started_r; // R10
endmodule : wdt_top

/* File: sim/wdt_props.sv */
// Port-level assertions for the watchdog top
`timescale 1ns/1ns
module wdt_props #(
	parameter int unsigned CPU_COUNT = 64,
	parameter int unsigned PRE_LO = 2
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic [1:0] s_bresp,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic [31:0] s_araddr,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic [31:0] s_rdata,
	input wire logic [1:0] s_rresp,
	input wire logic s_rvalid,
	input wire logic s_rready,
	// Power states and outputs
	input wire logic stop_mode,
	input wire logic wait_mode,
	input wire logic hold_state,
	input wire logic wdt_reset_req,
	input wire logic stop_entry_block
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [15:0] gap_r;
	logic seen_r;
	logic frz;
	assign frz = stop_mode | wait_mode | hold_state;
	// Cycles since the last reset request, to bound the shortest period
	always_ff @(posedge aclk)
	begin
		if (!aresetn || wdt_reset_req)
			gap_r <= 16'h0001;
		else
			gap_r <= gap_r + 16'h0001;
	end
	always_ff @(posedge aclk)
	begin
		seen_r <= aresetn && (seen_r || wdt_reset_req);
	end
	sequence s_wr_take;
		s_awvalid && s_awready && s_wvalid && s_wready;
	endsequence
	sequence s_rd_take;
		s_arvalid && s_arready;
	endsequence
	property p_wr_answer;
		s_wr_take |-> ##2 s_bvalid;
	endproperty
	property p_b_hold;
		s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
	endproperty
	property p_r_answer;
		s_rd_take |=> s_rvalid;
	endproperty
	property p_r_hold;
		s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
	endproperty
	property p_ar_block;
		s_rvalid |-> !s_arready;
	endproperty
	property p_unmapped;
		s_rd_take and (s_araddr == 32'h40) |=> s_rresp == 2'h2 && s_rdata == 32'h0;
	endproperty
	property p_pulse;
		wdt_reset_req |=> !wdt_reset_req;
	endproperty
	property p_gap;
		wdt_reset_req && seen_r |-> gap_r >= PRE_LO * CPU_COUNT;
	endproperty
	property p_frozen;
		frz && $past(frz) && $past(frz, 2) && !stop_entry_block |-> !wdt_reset_req;
	endproperty
	property p_block_sticky;
		stop_entry_block |=> stop_entry_block;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	a_pulse: assert property (p_pulse) else $error("reset request too long");
	a_gap: assert property (p_gap) else $error("watchdog period too short");
	a_frozen: assert property (p_frozen) else $error("counting while frozen");
	a_block_sticky: assert property (p_block_sticky) else $error("protection lost");
endmodule : wdt_props
bind wdt_top wdt_props #(.CPU_COUNT(CPU_COUNT), .PRE_LO(PRE_LO)) wdt_props_inst (
	.aclk(aclk), .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
	.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
	.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
	.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
	.stop_mode(stop_mode), .wait_mode(wait_mode), .hold_state(hold_state),
	.wdt_reset_req(wdt_reset_req), .stop_entry_block(stop_entry_block));

/* File: sim/testbench.sv */
// Self-checking testbench for the watchdog top
`timescale 1ns/1ns
module testbench;
	import wdt_pkg::*;
	localparam int unsigned CPC = 64;
	localparam int unsigned CSC = 16;
	logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic loco_clk_in, stop_mode, wait_mode, hold_state, wdt_irq, wdt_reset_req, stop_entry_block;
	logic [31:0] s_awaddr, s_wdata, s_araddr, s_rdata, rd;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp, rr, br;
	wdt_byte_t option_select_byte;
	int mismatches, compares, cyc, lc, n;
	wdt_top #(.CPU_COUNT(CPC), .CSP_COUNT(CSC), .PRE_LO(2), .PRE_HI(4)) wdt_top_inst (
		.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.loco_clk_in(loco_clk_in), .option_select_byte(option_select_byte),
		.stop_mode(stop_mode), .wait_mode(wait_mode), .hold_state(hold_state),
		.wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req), .stop_entry_block(stop_entry_block));
	initial
	begin
		aclk = 0;
		forever #10 aclk = ~aclk;
	end
	// Slow oscillator: 400 bus clocks a period
	always @(posedge aclk)
	begin
		lc <= (lc == 199) ? 0 : lc + 1;
		if (lc == 199)
			loco_clk_in <= ~loco_clk_in;
	end
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			mismatches++;
			close_out();
		end
	end
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1;
		s_wvalid <= 1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (s_awready && !ad)
			begin
				ad = 1;
				s_awvalid <= 0;
			end
			if (s_wready && !wd)
			begin
				wd = 1;
				s_wvalid <= 0;
			end
		end
		// Response left waiting one cycle so the hold check has work
		do @(posedge aclk); while (s_bvalid !== 1);
		s_bready <= 1;
		@(posedge aclk);
		br = s_bresp;
		s_bready <= 0;
	endtask : wr
	task automatic rdr(input logic [31:0] a);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1;
		do @(posedge aclk); while (s_arready !== 1);
		s_arvalid <= 0;
		@(posedge aclk);
		s_rready <= 1;
		do @(posedge aclk); while (s_rvalid !== 1);
		rd = s_rdata;
		rr = s_rresp;
		s_rready <= 0;
	endtask : rdr
	// Cycles from the call to the next reset request
	task automatic wait_rst;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (wdt_reset_req !== 1 && n < 20000);
	endtask : wait_rst
	task automatic do_reset(input wdt_byte_t o);
		@(posedge aclk);
		aresetn <= 0;
		option_select_byte <= o;
		repeat (20) @(posedge aclk);
		aresetn <= 1;
	endtask : do_reset
	task automatic t_start;
		rdr(32'h18);
		chk(rd, CPC - 1);
		repeat (300) @(posedge aclk);
		rdr(32'h18);
		chk(rd, CPC - 1);
		rdr(32'h40);
		chk(rr, 2'h2);
		chk(rd, 32'h0);
		wr(32'h40, 32'h1);
		chk(br, 2'h2);
		rdr(32'h3ffffc);
		chk(rd, 32'hff);
		wr(32'h4, 32'h0);
		chk(br, 2'h0);
		repeat (20) @(posedge aclk);
		rdr(32'h18);
		chk(rd < CPC - 1, 1);
		$display("start test done");
	endtask : t_start
	task automatic t_irq;
		wr(32'h14, 32'h1);
		n = 0;
		while (wdt_irq !== 1 && n < 400)
		begin
			@(posedge aclk);
			n++;
		end
		chk(wdt_irq, 1);
		rdr(32'h10);
		chk(rd, 32'h1);
		wr(32'h14, 32'h0);
		chk(wdt_irq, 0);
		wr(32'h14, 32'h1);
		chk(wdt_irq, 1);
		wr(32'h10, 32'h1);
		chk(wdt_irq, 0);
		$display("interrupt test done");
	endtask : t_irq
	task automatic t_refresh;
		do rdr(32'h18); while (rd >= 20);
		wr(32'h0, 32'h0);
		wr(32'h0, 32'hff);
		rdr(32'h18);
		chk(rd >= CPC - 4, 1);
		do rdr(32'h18); while (rd >= 40);
		wr(32'h0, 32'h0);
		wr(32'h0, 32'h55);
		wr(32'h0, 32'hff);
		rdr(32'h18);
		chk(rd < 40, 1);
		$display("refresh test done");
	endtask : t_refresh
	task automatic t_period;
		wr(32'h8, 32'h2);
		wait_rst();
		wait_rst();
		chk(n, 2 * CPC);
		wr(32'h8, 32'h82);
		wait_rst();
		wait_rst();
		chk(n, 4 * CPC);
		rdr(32'h10);
		chk(rd[1], 1);
		$display("period test done");
	endtask : t_period
	task automatic t_freeze;
		logic [31:0] c1;
		for (int i = 0; i < 3; i++)
		begin
			{hold_state, wait_mode, stop_mode} <= 3'h1 << i;
			rdr(32'h18);
			c1 = rd;
			repeat (50) @(posedge aclk);
			rdr(32'h18);
			chk(rd, c1);
			{hold_state, wait_mode, stop_mode} <= 3'h0;
			repeat (30) @(posedge aclk);
		end
		$display("freeze test done");
	endtask : t_freeze
	task automatic t_protect;
		wr(32'hc, 32'h80);
		rdr(32'hc);
		chk(rd, 32'h0);
		wr(32'hc, 32'h0);
		wr(32'hc, 32'h80);
		rdr(32'hc);
		chk(rd, 32'h80);
		chk(stop_entry_block, 1);
		wr(32'hc, 32'h0);
		rdr(32'hc);
		chk(rd, 32'h80);
		wr(32'h8, 32'h0);
		wait_mode <= 1;
		wait_rst();
		wait_rst();
		chk(n, CSC * 400);
		wait_mode <= 0;
		$display("protection test done");
	endtask : t_protect
	task automatic t_option;
		do_reset(8'h7e);
		rdr(32'hc);
		chk(rd, 32'h80);
		chk(stop_entry_block, 1);
		rdr(32'h3ffffc);
		chk(rd, 32'h7e);
		wr(32'h3ffffc, 32'hff);
		chk(br, 2'h0);
		rdr(32'h3ffffc);
		chk(rd, 32'h7e);
		repeat (900) @(posedge aclk);
		rdr(32'h18);
		chk(rd < CSC - 1, 1);
		do_reset(8'hfe);
		repeat (50) @(posedge aclk);
		rdr(32'h18);
		chk(rd < CPC - 1, 1);
		$display("option test done");
	endtask : t_option
	initial
	begin
		{aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h0;
		{loco_clk_in, stop_mode, wait_mode, hold_state} = 4'h0;
		{s_awaddr, s_wdata, s_araddr} = 96'h0;
		s_wstrb = 4'hf;
		option_select_byte = 8'hff;
		{mismatches, compares, cyc, lc} = 0;
		do_reset(8'hff);
		t_start();
		t_irq();
		t_refresh();
		t_period();
		t_freeze();
		t_protect();
		t_option();
		close_out();
	end
endmodule : testbench
